// *** inc/lss_pkg.sv ***
// Purpose: Constants and carriers for the light sensor status bank.
// Assumes: Register indices are word indices; byte address is 4 x index.
// Notes: Offsets, field bit positions, resets and counts live here; the irq status bit order and COUNTS_PER_STEP are set in the bank.
package lss_pkg;
  // ******************************************************
  // Register indices
  // ******************************************************
  localparam logic [7:0] LSS_IDX_PRIMARY = 8'h93;
  localparam logic [7:0] LSS_IDX_SAT = 8'ha3;
  localparam logic [7:0] LSS_IDX_THR = 8'ha4;
  localparam logic [7:0] LSS_IDX_SYS = 8'ha6;
  localparam logic [7:0] LSS_IDX_EXEC = 8'ha7;
  localparam logic [7:0] LSS_IDX_CTRL = 8'hb0;
  localparam logic [7:0] LSS_IDX_ITIME = 8'hb1;
  localparam logic [7:0] LSS_IDX_WAIT_TIME = 8'hb2;
  localparam logic [7:0] LSS_IDX_IRQ_ST = 8'hb4;
  localparam logic [7:0] LSS_IDX_IRQ_MASK = 8'hb5;
  // ******************************************************
  // Field positions
  // ******************************************************
  localparam int LSS_B_LVALID = 6;
  localparam int LSS_B_LDSAT = 4;
  localparam int LSS_B_LASAT = 3;
  localparam int LSS_B_FASAT = 1;
  localparam int LSS_B_FDSAT = 0;
  localparam int LSS_B_HIGH = 5;
  localparam int LSS_B_LOW = 4;
  localparam int LSS_B_FSYS = 3;
  localparam int LSS_B_OVT = 5;
  localparam int LSS_B_FTERR = 4;
  localparam int LSS_B_LTERR = 2;
  localparam int LSS_B_SAI = 1;
  localparam int LSS_B_BUSY = 0;
  localparam int LSS_B_P_SAT = 7;
  localparam int LSS_B_P_LIRQ = 3;
  localparam int LSS_B_P_SYS = 0;
  localparam int LSS_B_C_LEN = 0;
  localparam int LSS_B_C_FSIEN = 1;
  localparam int LSS_B_C_SYSTEM_IRQ_ENABLE = 2;
  localparam int LSS_B_C_SLEEP = 3;
  localparam int LSS_IRQ_W = 6;
  // ******************************************************
  // Reset values and counts
  // ******************************************************
  localparam logic [7:0] LSS_THR_RESERVED = 8'h08;
  localparam logic [7:0] LSS_RST_ZERO = 8'h00;
  localparam int LSS_INIT_US = 300;
  localparam int LSS_CLK_MHZ = 10;
  localparam int LSS_INIT_CYCLES = LSS_INIT_US * LSS_CLK_MHZ;
  localparam int LSS_SYNC_W = 3;
  // ******************************************************
  // Carriers
  // ******************************************************
  typedef struct packed {
    logic light_cycle_done;
    logic light_status_read;
    logic [15:0] light_count;
    logic [15:0] flicker_count;
    logic light_irq_high;
    logic light_irq_low;
    logic flicker_timing_error;
    logic [7:0] flicker_result_status;
  } lss_sense_t;
  typedef struct packed {
    logic over_temperature;
    logic flicker_frontend_saturated;
    logic light_frontend_saturated;
  } lss_async_t;
endpackage

// *** hw/lss_status_regs.sv ***
// Purpose: Auxiliary status register bank of a light and flicker sensor.
// Assumes: One clock; Avalon-MM slave with one wait state per access.
// Notes: Write one to clear on primary, exec over-temp and irq status.
// Operation
// - Light-valid sets after a full cycle since enable or status read.
// - Light counter saturation sets when count reaches its time-based max.
// - Light front end saturation sets on analog overload.
// - Flicker front end saturation sets on analog overload.
// - Flicker counter saturation sets when its count reaches maximum.
// - High-threshold cause sets when interrupt came from high threshold.
// - Low-threshold cause sets when interrupt came from low threshold.
// - Flicker result change sets system event bit when enabled.
// - Over-temperature sets on heat, clears only by writing one.
// - Flicker timing error shows a flicker trigger timing fault.
// - Light timing error shows wait time too short for integration.
// - Sleep-after-interrupt flag is set while held in that sleep.
// - Clearing the sleep flag releases the device from sleep.
// - Init busy reads one for 300 us after reset, then clears.
// - Primary status clears bits written one, keeps bits written zero.
// - System event appears in primary bit 0 when enabled.
//
// Our own choice: the Avalon-MM slave port.
`timescale 1ns/1ps
module lss_status_regs
  import lss_pkg::*;
#(
  parameter int COUNT_W = 16,
  parameter int COUNTS_PER_STEP = 1024
) (
  input wire logic mclk_in,
  input wire logic reset_n_in,
  input wire logic ce_in,
  input wire logic [9:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  input wire lss_sense_t sense_in,
  input wire lss_async_t async_in,
  output logic sleep_out,
  output logic light_enable_out,
  output logic irq_out
);
  if (COUNT_W != 16 || COUNTS_PER_STEP < 1) begin : g_bad_params
    $error("lss_status_regs: unsupported parameters");
  end

  // ******************************************************
  // Bus slave
  // ******************************************************
  logic ack;
  logic busy;
  logic [7:0] idx;
  logic wr_go;
  logic rd_go;
  logic [7:0] wd;
  assign idx = avs_address_in[9:2];
  assign wd = avs_writedata_in[7:0];
  // The ack flop inserts exactly one wait state per access.
  // Ack drops for a cycle after each answer, so back to back
  // requests each see waitrequest high first.
  assign avs_waitrequest_out = (avs_read_in | avs_write_in) & ~ack;
  assign rd_go = avs_read_in & ack & ce_in;
  // Writes during initialization are dropped.
  assign wr_go = avs_write_in & ack & ce_in & ~busy;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
    hit = (a == r);
  endfunction

  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ack <= 1'b0;
    end else if (ce_in) begin
      ack <= (avs_read_in | avs_write_in) & ~ack;
    end
  end

  // ******************************************************
  // Input synchronisers
  // ******************************************************
  logic [LSS_SYNC_W-1:0] s1;
  logic [LSS_SYNC_W-1:0] s2;
  logic [LSS_SYNC_W-1:0] s3;
  logic [LSS_SYNC_W-1:0] aq;
  // The filter stage follows only once two stages agree, so a
  // glitch of a single cycle on a pin is never reported.
  generate
    for (genvar g = 0; g < LSS_SYNC_W; g++) begin : g_sync
      always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
          s1[g] <= 1'b0;
          s2[g] <= 1'b0;
          s3[g] <= 1'b0;
          aq[g] <= 1'b0;
        end else if (ce_in) begin
          s1[g] <= async_in[g];
          s2[g] <= s1[g];
          s3[g] <= s2[g];
          if (s2[g] == s3[g]) begin
            aq[g] <= s3[g];
          end
        end
      end
    end
  endgenerate
  logic a_lsat;
  logic a_fsat;
  logic a_ovt;
  assign a_lsat = aq[0];
  assign a_fsat = aq[1];
  assign a_ovt = aq[2];

  // ******************************************************
  // Configuration
  // ******************************************************
  logic [7:0] ctrl;
  logic [7:0] light_integration_time;
  logic [7:0] wait_time;
  logic [LSS_IRQ_W-1:0] irq_mask;
  logic light_enable;
  logic flicker_system_irq_enable;
  logic system_irq_enable;
  assign light_enable = ctrl[LSS_B_C_LEN];
  assign flicker_system_irq_enable = ctrl[LSS_B_C_FSIEN];
  assign system_irq_enable = ctrl[LSS_B_C_SYSTEM_IRQ_ENABLE];
  assign light_enable_out = light_enable;

  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ctrl <= LSS_RST_ZERO;
      light_integration_time <= LSS_RST_ZERO;
      wait_time <= LSS_RST_ZERO;
      irq_mask <= '0;
    end else if (wr_go) begin
      if (hit(idx, LSS_IDX_CTRL)) begin
        ctrl <= {4'h0, wd[3:0]};
      end
      if (hit(idx, LSS_IDX_ITIME)) begin
        light_integration_time <= wd;
      end
      if (hit(idx, LSS_IDX_WAIT_TIME)) begin
        wait_time <= wd;
      end
      if (hit(idx, LSS_IDX_IRQ_MASK)) begin
        irq_mask <= wd[LSS_IRQ_W-1:0];
      end
    end
  end

  // ******************************************************
  // Initialization timer
  // ******************************************************
  // The counter stops once busy falls, so it can never wrap.
  logic [11:0] init_cnt;
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      init_cnt <= '0;
      busy <= 1'b1;
    end else if (ce_in && busy) begin
      // Busy holds for the whole settling time.
      if (init_cnt == 12'(LSS_INIT_CYCLES - 1)) begin
        busy <= 1'b0;
      end else begin
        init_cnt <= init_cnt + 12'h001;
      end
    end
  end

  // ******************************************************
  // Event detection
  // ******************************************************
  // The limit is clamped because long integration times would
  // otherwise ask for more than the 16-bit counter can reach.
  function automatic logic [15:0] light_max(input logic [7:0] t);
    int unsigned m;
    m = (int'(t) + 1) * COUNTS_PER_STEP - 1;
    if (m > 32'h0000ffff) begin
      m = 32'h0000ffff;
    end
    light_max = m[15:0];
  endfunction

  // The previous flicker status is kept to spot any change of it.
  logic en_q;
  logic [7:0] fstat_q;
  logic ev_lvalid;
  logic ev_ldsat;
  logic ev_fdsat;
  logic ev_fchg;
  logic ev_lirq;
  logic ev_sys;
  // Enable rising restarts the valid window.
  assign ev_lvalid = sense_in.light_cycle_done & light_enable & en_q;
  assign ev_ldsat = sense_in.light_count >= light_max(light_integration_time);
  assign ev_fdsat = &sense_in.flicker_count;
  assign ev_fchg = (sense_in.flicker_result_status != fstat_q) &
                   flicker_system_irq_enable;
  assign ev_lirq = sense_in.light_irq_high | sense_in.light_irq_low;

  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      en_q <= 1'b0;
      fstat_q <= LSS_RST_ZERO;
    end else if (ce_in) begin
      en_q <= light_enable;
      fstat_q <= sense_in.flicker_result_status;
    end
  end

  // ******************************************************
  // Saturation and valid register
  // ******************************************************
  logic [7:0] sat_reg;
  logic sat_rd;
  logic lclr;
  assign sat_rd = rd_go & hit(idx, LSS_IDX_SAT);
  assign lclr = (sense_in.light_status_read | (light_enable & ~en_q));
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      sat_reg <= LSS_RST_ZERO;
    end else if (ce_in) begin
      // Set terms win over clear terms in every bit.
      sat_reg[LSS_B_LVALID] <= ev_lvalid |
        (sat_reg[LSS_B_LVALID] & ~lclr);
      sat_reg[LSS_B_LDSAT] <= ev_ldsat |
        (sat_reg[LSS_B_LDSAT] & ~sense_in.light_status_read);
      sat_reg[LSS_B_LASAT] <= a_lsat |
        (sat_reg[LSS_B_LASAT] & ~sense_in.light_status_read);
      sat_reg[LSS_B_FASAT] <= a_fsat |
        (sat_reg[LSS_B_FASAT] & ~sat_rd);
      sat_reg[LSS_B_FDSAT] <= ev_fdsat |
        (sat_reg[LSS_B_FDSAT] & ~sat_rd);
    end
  end

  // ******************************************************
  // Primary status
  // ******************************************************
  logic [7:0] primary;
  logic p_wr;
  logic sat_any;
  logic [7:0] p_clr;
  assign p_wr = wr_go & hit(idx, LSS_IDX_PRIMARY);
  assign p_clr = p_wr ? wd : 8'h00;
  assign sat_any = ev_ldsat | ev_fdsat | a_lsat | a_fsat;
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      primary <= LSS_RST_ZERO;
    end else if (ce_in) begin
      // Only ones written clear; zeros keep pending events.
      primary[LSS_B_P_SAT] <= sat_any |
        (primary[LSS_B_P_SAT] & ~p_clr[LSS_B_P_SAT]);
      primary[LSS_B_P_LIRQ] <= ev_lirq |
        (primary[LSS_B_P_LIRQ] & ~p_clr[LSS_B_P_LIRQ]);
      primary[LSS_B_P_SYS] <= (ev_sys & system_irq_enable) |
        (primary[LSS_B_P_SYS] & ~p_clr[LSS_B_P_SYS]);
    end
  end

  // ******************************************************
  // Threshold cause and system event
  // ******************************************************
  logic [7:0] thr_reg;
  logic [7:0] sys_reg;
  logic lirq_clr;
  logic sys_clr;
  assign lirq_clr = p_clr[LSS_B_P_LIRQ];
  assign sys_clr = p_clr[LSS_B_P_SYS];
  assign ev_sys = ev_fchg;
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      thr_reg <= LSS_THR_RESERVED;
      sys_reg <= LSS_RST_ZERO;
    end else if (ce_in) begin
      thr_reg[LSS_B_HIGH] <= sense_in.light_irq_high |
        (thr_reg[LSS_B_HIGH] & ~lirq_clr);
      thr_reg[LSS_B_LOW] <= sense_in.light_irq_low |
        (thr_reg[LSS_B_LOW] & ~lirq_clr);
      sys_reg[LSS_B_FSYS] <= ev_fchg |
        (sys_reg[LSS_B_FSYS] & ~sys_clr);
    end
  end

  // ******************************************************
  // Execution status
  // ******************************************************
  logic ovt;
  logic sai;
  logic e_wr;
  logic lterr;
  assign e_wr = wr_go & hit(idx, LSS_IDX_EXEC);
  assign lterr = light_enable & (wait_time < light_integration_time);
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ovt <= 1'b0;
      sai <= 1'b0;
    end else if (ce_in) begin
      ovt <= a_ovt | (ovt & ~(e_wr & wd[LSS_B_OVT]));
      sai <= (ev_lirq & ctrl[LSS_B_C_SLEEP]) |
             (sai & ~(e_wr & wd[LSS_B_SAI]));
    end
  end
  assign sleep_out = sai;

  // The timing error bits are live and clear on their own once
  // the cause goes away.
  logic [7:0] exec_reg;
  always_comb begin
    exec_reg = LSS_RST_ZERO;
    exec_reg[LSS_B_OVT] = ovt;
    exec_reg[LSS_B_FTERR] = sense_in.flicker_timing_error;
    exec_reg[LSS_B_LTERR] = lterr;
    exec_reg[LSS_B_SAI] = sai;
    exec_reg[LSS_B_BUSY] = busy;
  end

  // ******************************************************
  // Interrupt status
  // ******************************************************
  logic [LSS_IRQ_W-1:0] irq_st;
  logic [LSS_IRQ_W-1:0] irq_ev;
  logic [LSS_IRQ_W-1:0] irq_clr;
  assign irq_ev = {sense_in.flicker_timing_error | lterr, a_ovt, ev_fchg,
                   ev_lirq, sat_any, ev_lvalid};
  assign irq_clr = (wr_go && hit(idx, LSS_IDX_IRQ_ST)) ?
                   wd[LSS_IRQ_W-1:0] : '0;
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      irq_st <= '0;
    end else if (ce_in) begin
      irq_st <= irq_ev | (irq_st & ~irq_clr);
    end
  end
  // The level output stays high while any unmasked event is pending.
  assign irq_out = |(irq_st & irq_mask);

  // ******************************************************
  // Read data
  // ******************************************************
  logic [7:0] rmux;
  always_comb begin
    // Reserved bits read their reset value; unmapped reads zero.
    unique case (idx)
      LSS_IDX_PRIMARY: rmux = primary;
      LSS_IDX_SAT: rmux = sat_reg;
      LSS_IDX_THR: rmux = thr_reg;
      LSS_IDX_SYS: rmux = sys_reg;
      LSS_IDX_EXEC: rmux = exec_reg;
      LSS_IDX_CTRL: rmux = ctrl;
      LSS_IDX_ITIME: rmux = light_integration_time;
      LSS_IDX_WAIT_TIME: rmux = wait_time;
      LSS_IDX_IRQ_ST: rmux = {2'b00, irq_st};
      LSS_IDX_IRQ_MASK: rmux = {2'b00, irq_mask};
      default: rmux = LSS_RST_ZERO;
    endcase
  end

  // Read data is captured in the first cycle of the request, so a
  // read-clear at the answer edge never hides the flag being read.
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      avs_readdata_out <= '0;
    end else if (ce_in && avs_read_in && !ack) begin
      avs_readdata_out <= {24'h000000, rmux};
    end
  end
endmodule

// *** testbench/lss_status_properties.sv ***
// Purpose: Port-level checks of the light sensor status bank.
// Assumes: The bench holds the clock enable high.
// Notes: Bound into every instance of the status bank.
`timescale 1ns/1ps
module lss_status_properties
  import lss_pkg::*;
(
  input wire logic mclk_in,
  input wire logic reset_n_in,
  input wire logic ce_in,
  input wire logic [9:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [31:0] avs_readdata_out,
  input wire logic avs_waitrequest_out,
  input wire lss_sense_t sense_in,
  input wire lss_async_t async_in,
  input wire logic sleep_out,
  input wire logic light_enable_out,
  input wire logic irq_out
);
  logic [12:0] up_cnt;
  wire req = avs_read_in || avs_write_in;
  wire wr_ok = avs_write_in && !avs_waitrequest_out;
  wire sleep_wr = wr_ok && avs_address_in[9:2] == LSS_IDX_EXEC &&
    avs_writedata_in[LSS_B_SAI];
  wire irq_any = sense_in.light_irq_high || sense_in.light_irq_low;
  // ********
  // Cycles since reset, saturating, to place the init window.
  // ********
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      up_cnt <= 13'h0;
    end else if (ce_in && up_cnt != 13'h1fff) begin
      up_cnt <= up_cnt + 13'h1;
    end
  end
  default clocking @(posedge mclk_in);
  endclocking
  default disable iff (!reset_n_in);
  sequence rd_ack(idx);
    avs_read_in && !avs_waitrequest_out && avs_address_in[9:2] == idx;
  endsequence
  sequence wr_ack(idx);
    wr_ok && avs_address_in[9:2] == idx;
  endsequence
  // ********
  // Assertions
  // ********
  wait_ack_a: assert property ($rose(req) |=> !avs_waitrequest_out)
    else $error("request not answered after one cycle");
  busy_early_a: assert property (
    rd_ack(LSS_IDX_EXEC) ##0 (up_cnt < 13'hbae) |-> avs_readdata_out[0])
    else $error("init busy low too early");
  busy_late_a: assert property (
    rd_ack(LSS_IDX_EXEC) ##0 (up_cnt > 13'hbc2) |-> !avs_readdata_out[0])
    else $error("init busy still high");
  busy_drop_a: assert property (
    wr_ack(LSS_IDX_CTRL) ##0 (up_cnt < 13'hbae)
    |=> $stable(light_enable_out))
    else $error("write taken during init");
  enable_write_a: assert property (
    wr_ack(LSS_IDX_CTRL) ##0 (up_cnt > 13'hbc2)
    |=> light_enable_out == $past(avs_writedata_in[0]))
    else $error("light enable not written");
  sleep_rise_a: assert property (
    $rose(sleep_out) |-> $past(irq_any))
    else $error("sleep entered without light interrupt");
  sleep_fall_a: assert property (
    $fell(sleep_out) |-> $past(sleep_wr))
    else $error("sleep left without clear");
  sleep_clear_a: assert property (
    sleep_wr && !irq_any && up_cnt > 13'hbc2 |=> !sleep_out)
    else $error("sleep clear ignored");
  sleep_read_a: assert property (
    rd_ack(LSS_IDX_EXEC) |-> avs_readdata_out[1] == $past(sleep_out))
    else $error("sleep flag read differs from sleep");
  thr_reserved_a: assert property (
    rd_ack(LSS_IDX_THR) |-> avs_readdata_out[3:0] == 4'h8)
    else $error("threshold reserved bits wrong");
  upper_zero_a: assert property (
    avs_readdata_out[31:8] == 24'h0)
    else $error("upper read data not zero");
endmodule
bind lss_status_regs lss_status_properties chk_u (
  .mclk_in(mclk_in), .reset_n_in(reset_n_in), .ce_in(ce_in),
  .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
  .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
  .avs_readdata_out(avs_readdata_out),
  .avs_waitrequest_out(avs_waitrequest_out), .sense_in(sense_in),
  .async_in(async_in), .sleep_out(sleep_out),
  .light_enable_out(light_enable_out), .irq_out(irq_out)
);

// *** testbench/light_sensor_status_regs_bench.sv ***
// Purpose: Register-level tests of the light sensor status bank.
// Assumes: Clock enable held high; bus reached only through tasks.
// Notes: Sense bit positions follow the field order of lss_sense_t.
`timescale 1ns/1ps
module light_sensor_status_regs_bench
  import lss_pkg::*;
;
  localparam int P_DONE = 44;
  localparam int P_READ = 43;
  localparam int P_HIGH = 10;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [9:0] addr = 10'h0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata;
  logic [31:0] d;
  logic wreq;
  logic sleep;
  logic len;
  logic irq;
  lss_sense_t sense = '0;
  lss_async_t asy = '0;
  int errors = 0;
  int cmp_count = 0;
  lss_status_regs dut_u (
    .mclk_in(clk), .reset_n_in(rst_n), .ce_in(1'b1),
    .avs_address_in(addr), .avs_read_in(rd), .avs_write_in(wr),
    .avs_writedata_in(wdata), .avs_readdata_out(rdata),
    .avs_waitrequest_out(wreq), .sense_in(sense), .async_in(asy),
    .sleep_out(sleep), .light_enable_out(len), .irq_out(irq)
  );
  // ********
  // Tasks
  // ********
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %0t got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] idx,
    input logic [7:0] v);
    addr <= {idx, 2'b00};
    wdata <= {24'h0, v};
    rd <= !w;
    wr <= w;
    @(posedge clk);
    // Only the watchdog ends a wait for the answer.
    while (wreq !== 1'b0) begin
      @(posedge clk);
    end
    d = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wreg(input logic [7:0] idx, input logic [7:0] v);
    bus(1'b1, idx, v);
  endtask
  task automatic rchk(input logic [7:0] idx, input logic [7:0] exp);
    bus(1'b0, idx, 8'h00);
    check(d, {24'h0, exp});
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic pulse(input int k);
    sense[k] <= 1'b1;
    @(posedge clk);
    sense[k] <= 1'b0;
    @(posedge clk);
  endtask
  task automatic give_verdict();
    $display("Compares %0d, mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // ********
  // Clock, watchdog and tests
  // ********
  initial begin
    forever #50 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    give_verdict();
  end
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rchk(LSS_IDX_EXEC, 8'h01);
    rchk(LSS_IDX_SAT, 8'h00);
    rchk(LSS_IDX_THR, 8'h08);
    rchk(LSS_IDX_SYS, 8'h00);
    wreg(LSS_IDX_CTRL, 8'h07);
    check(len, 1'b0);
    tick(2900);
    rchk(LSS_IDX_EXEC, 8'h01);
    tick(120);
    rchk(LSS_IDX_EXEC, 8'h00);
    wreg(LSS_IDX_ITIME, 8'h00);
    wreg(LSS_IDX_WAIT_TIME, 8'h00);
    wreg(LSS_IDX_CTRL, 8'h07);
    check(len, 1'b1);
    pulse(P_DONE);
    rchk(LSS_IDX_SAT, 8'h40);
    pulse(P_READ);
    rchk(LSS_IDX_SAT, 8'h00);
    sense.light_count <= 16'h03fe;
    tick(2);
    rchk(LSS_IDX_SAT, 8'h00);
    sense.light_count <= 16'h03ff;
    tick(2);
    rchk(LSS_IDX_SAT, 8'h10);
    sense.light_count <= 16'h0000;
    pulse(P_READ);
    sense.flicker_count <= 16'hffff;
    tick(2);
    sense.flicker_count <= 16'h0000;
    tick(1);
    rchk(LSS_IDX_SAT, 8'h01);
    rchk(LSS_IDX_SAT, 8'h00);
    asy <= 3'b111;
    tick(10);
    asy <= 3'b000;
    tick(10);
    rchk(LSS_IDX_SAT, 8'h0a);
    pulse(P_READ);
    rchk(LSS_IDX_SAT, 8'h00);
    rchk(LSS_IDX_EXEC, 8'h20);
    wreg(LSS_IDX_EXEC, 8'h00);
    rchk(LSS_IDX_EXEC, 8'h20);
    wreg(LSS_IDX_EXEC, 8'h20);
    rchk(LSS_IDX_EXEC, 8'h00);
    rchk(LSS_IDX_PRIMARY, 8'h80);
    wreg(LSS_IDX_PRIMARY, 8'h00);
    rchk(LSS_IDX_PRIMARY, 8'h80);
    wreg(LSS_IDX_PRIMARY, 8'h80);
    rchk(LSS_IDX_PRIMARY, 8'h00);
    pulse(P_HIGH);
    rchk(LSS_IDX_THR, 8'h28);
    pulse(P_HIGH - 1);
    rchk(LSS_IDX_THR, 8'h38);
    rchk(LSS_IDX_PRIMARY, 8'h08);
    wreg(LSS_IDX_PRIMARY, 8'h08);
    rchk(LSS_IDX_THR, 8'h08);
    sense.flicker_result_status <= 8'h21;
    tick(2);
    rchk(LSS_IDX_SYS, 8'h08);
    rchk(LSS_IDX_PRIMARY, 8'h01);
    wreg(LSS_IDX_PRIMARY, 8'h01);
    rchk(LSS_IDX_SYS, 8'h00);
    wreg(LSS_IDX_CTRL, 8'h01);
    sense.flicker_result_status <= 8'h00;
    tick(2);
    rchk(LSS_IDX_SYS, 8'h00);
    rchk(LSS_IDX_PRIMARY, 8'h00);
    wreg(LSS_IDX_ITIME, 8'h05);
    rchk(LSS_IDX_EXEC, 8'h04);
    wreg(LSS_IDX_WAIT_TIME, 8'h05);
    rchk(LSS_IDX_EXEC, 8'h00);
    sense.flicker_timing_error <= 1'b1;
    tick(2);
    rchk(LSS_IDX_EXEC, 8'h10);
    sense.flicker_timing_error <= 1'b0;
    wreg(LSS_IDX_IRQ_MASK, 8'h00);
    wreg(LSS_IDX_IRQ_ST, 8'h3f);
    wreg(LSS_IDX_CTRL, 8'h09);
    pulse(P_HIGH);
    check(sleep, 1'b1);
    check(irq, 1'b0);
    rchk(LSS_IDX_IRQ_ST, 8'h04);
    rchk(LSS_IDX_EXEC, 8'h02);
    wreg(LSS_IDX_EXEC, 8'h00);
    check(sleep, 1'b1);
    wreg(LSS_IDX_EXEC, 8'h02);
    check(sleep, 1'b0);
    wreg(LSS_IDX_IRQ_MASK, 8'h04);
    check(irq, 1'b1);
    wreg(LSS_IDX_IRQ_ST, 8'h04);
    check(irq, 1'b0);
    wreg(LSS_IDX_THR, 8'hff);
    rchk(LSS_IDX_THR, 8'h28);
    wreg(8'h10, 8'hff);
    rchk(8'h10, 8'h00);
    wreg(LSS_IDX_SAT, 8'hff);
    rchk(LSS_IDX_SAT, 8'h00);
    give_verdict();
  end
endmodule
